// ---- design/slhv_defs.vh ----
`ifndef SLHV_DEFS_VH
`define SLHV_DEFS_VH
// What this block does
// - Output gate low: every high-voltage output pulled to ground.
// - Output gate high: outputs with latched one drive boost rail level.
// - Shutdown or soft start: ignore output gate, all outputs high impedance.
// - Load strobe active low; serial bits ignored unless strobe low.
// - Strobe rising edge copies shift register into selected holding latch.
// - Shift register is 24 bits wide, fed by serial clock and data.
// - Sample data on serial clock falling edge, shifting toward MSB.
// - Strobe high: shift register untouched by clock activity.
// - Strobe falling edge clears shift register, starts new word.
// - Strobe edges acted on independent of serial clock timing.
// - Latched values kept until overwritten or power-on reset.
// - Power-on reset clears latches and shift register to zero.
// - Word bit 0 picks destination: 0 configuration, 1 output pattern.
// - Pattern word sets 21 outputs (line variant) or 19 (boost variant).
// - Config bit 8: 0 current limit on, 1 limiter off.
// - Config bit 7: 1 stop switching at next pwm rising edge, else at once.
// - Config bit 6: 0 soft start enabled, 1 skip soft start.
// - Config bits 5:4 select limit 200 mA, 600 mA, 1 A, above 1.5 A.
// - Config bits 3:1 boost level; 000 shutdown with outputs high impedance.
// - Pattern word bits 21:1 map to outputs 20:0, one drives high.
// - Soft start (boost variant only) holds limit near 200 mA for 16384 pwm cycles.
// ====================================================================
// Word layout
`define SLHV_WORD_W 24
`define SLHV_SEL_BIT 0
`define SLHV_CFG_W 9
`define SLHV_CFG_MASK 9'h1ff
`define SLHV_CFG_LIMOFF 8
`define SLHV_CFG_SYNC 7
`define SLHV_CFG_SSOFF 6
`define SLHV_CFG_ILIM_HI 5
`define SLHV_CFG_ILIM_LO 4
`define SLHV_CFG_LVL_HI 3
`define SLHV_CFG_LVL_LO 1
`define SLHV_PAT_HI 21
`define SLHV_PAT_LO 1
`define SLHV_OUT_N 21
`define SLHV_OUT_N_BOOST 19
`define SLHV_LVL_SHUTDOWN 3'h0
`define SLHV_ILIM_200MA 2'h0
// ====================================================================
// Soft start
`define SLHV_SS_CYCLES 16384
`define SLHV_SS_W 15
`endif

// ---- design/slhv_sync.v ----
`timescale 1ns/1ps
module slhv_sync #(
  parameter W = 1,
  // Reset level matches the pin's idle level so no false edge follows reset
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Raw pins and synchronised copies
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  // ====================================================================
  // Two stage synchroniser; first stage feeds only the second
  always @(posedge clk) begin
    if (srst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ---- design/slhv_softstart.v ----
`timescale 1ns/1ps
`include "slhv_defs.vh"
module slhv_softstart #(
  parameter SS_CYCLES = `SLHV_SS_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Control
  input wire boost_on,
  input wire softstart_off,
  input wire pwm_rise,
  // Status
  output reg active
);
  reg [`SLHV_SS_W-1:0] cnt_q;
  reg boost_on_q;
  // ====================================================================
  // Restarts whenever boost leaves shutdown with soft start enabled; counts pwm rising edges
  always @(posedge clk) begin
    if (srst) begin
      cnt_q <= {`SLHV_SS_W{1'b0}};
      boost_on_q <= 1'b0;
      active <= 1'b0;
    end else begin
      boost_on_q <= boost_on;
      if (!boost_on || softstart_off) begin
        active <= 1'b0;
        cnt_q <= {`SLHV_SS_W{1'b0}};
      end else if (!boost_on_q) begin
        active <= 1'b1;
        cnt_q <= {`SLHV_SS_W{1'b0}};
      end else if (active && pwm_rise) begin
        if (cnt_q == SS_CYCLES[`SLHV_SS_W-1:0] - 1'b1) begin
          active <= 1'b0;
        end
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ---- design/slhv_top.v ----
`timescale 1ns/1ps
`include "slhv_defs.vh"
module slhv_top #(
  parameter BOOST_VARIANT = 1,
  parameter SS_CYCLES = `SLHV_SS_CYCLES
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Serial link pins
  input wire serial_clk,
  input wire serial_data,
  input wire load_strobe_n,
  // Output gate and boost pwm pins
  input wire output_gate,
  input wire boost_pwm_in,
  // High-voltage outputs: level and drive enable (low enable is high impedance)
  output reg [`SLHV_OUT_N-1:0] hv_output,
  output reg [`SLHV_OUT_N-1:0] hv_output_oe,
  // Boost control towards the analog regulator
  output reg [2:0] boost_level_sel,
  output reg [1:0] current_limit_sel,
  output reg limiter_off,
  output reg regulator_sync_release,
  output reg softstart_off,
  output reg softstart_active,
  output reg shutdown
);
  // ====================================================================
  // Synchronised pins
  wire sclk_s;
  wire sdat_s;
  wire strobe_n_s;
  wire gate_s;
  wire pwm_s;
  reg sclk_q;
  reg strobe_n_q;
  reg pwm_q;
  reg [`SLHV_WORD_W-1:0] shift_q;
  reg [`SLHV_CFG_W-1:0] cfg_q;
  reg [`SLHV_OUT_N-1:0] pattern_q;
  wire ss_active;
  wire sclk_fall;
  wire strobe_fall;
  wire strobe_rise;
  wire pwm_rise;
  wire boost_on;
  wire [`SLHV_OUT_N-1:0] out_mask;

  // Next values of latches and outputs
  reg [`SLHV_WORD_W-1:0] shift_d;
  reg [`SLHV_CFG_W-1:0] cfg_d;
  reg [`SLHV_OUT_N-1:0] pattern_d;
  reg [`SLHV_OUT_N-1:0] hv_output_d;
  reg [`SLHV_OUT_N-1:0] hv_output_oe_d;
  reg [2:0] boost_level_sel_d;
  reg [1:0] current_limit_sel_d;
  reg limiter_off_d;
  reg regulator_sync_release_d;
  reg softstart_off_d;
  reg softstart_active_d;
  reg shutdown_d;
  wire shift_en;
  wire pattern_pick;
  wire [2:0] level_code;
  wire [1:0] limit_code;
  wire ss_boost_on;

  // ====================================================================
  // Helpers
  function edge_rise;
    input prev_lvl;
    input cur_lvl;
    begin
      edge_rise = ~prev_lvl & cur_lvl;
    end
  endfunction

  function edge_fall;
    input prev_lvl;
    input cur_lvl;
    begin
      edge_fall = prev_lvl & ~cur_lvl;
    end
  endfunction

  // Boost variant drives fewer outputs; the rest stay high impedance
  function [`SLHV_OUT_N-1:0] variant_mask;
    input integer boost_variant;
    begin
      if (boost_variant != 0) begin
        variant_mask = {{(`SLHV_OUT_N-`SLHV_OUT_N_BOOST){1'b0}}, {`SLHV_OUT_N_BOOST{1'b1}}};
      end else begin
        variant_mask = {`SLHV_OUT_N{1'b1}};
      end
    end
  endfunction

  // One synchroniser per pin, each reset to the pin's idle level
  slhv_sync #(
    .W(1)
  ) u_sync_sclk (
    .clk(clk),
    .srst(srst),
    .d(serial_clk),
    .q(sclk_s)
  );

  slhv_sync #(
    .W(1)
  ) u_sync_sdat (
    .clk(clk),
    .srst(srst),
    .d(serial_data),
    .q(sdat_s)
  );

  slhv_sync #(
    .W(1),
    .INIT(1'b1)
  ) u_sync_strobe (
    .clk(clk),
    .srst(srst),
    .d(load_strobe_n),
    .q(strobe_n_s)
  );

  slhv_sync #(
    .W(1)
  ) u_sync_gate (
    .clk(clk),
    .srst(srst),
    .d(output_gate),
    .q(gate_s)
  );

  slhv_sync #(
    .W(1)
  ) u_sync_pwm (
    .clk(clk),
    .srst(srst),
    .d(boost_pwm_in),
    .q(pwm_s)
  );

  // ====================================================================
  // Edge detectors
  // Only the second synchroniser stage is looked at
  always @(posedge clk) begin
    if (srst) begin
      sclk_q <= 1'b0;
      strobe_n_q <= 1'b1;
      pwm_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      strobe_n_q <= strobe_n_s;
      pwm_q <= pwm_s;
    end
  end

  assign sclk_fall = edge_fall(sclk_q, sclk_s);
  assign strobe_fall = edge_fall(strobe_n_q, strobe_n_s);
  assign strobe_rise = edge_rise(strobe_n_q, strobe_n_s);
  assign pwm_rise = edge_rise(pwm_q, pwm_s);

  // ====================================================================
  // Shift register
  // shift only while selected
  assign shift_en = ~strobe_n_s & ~strobe_n_q & sclk_fall;

  always @* begin
    shift_d = shift_q;
    if (strobe_fall) begin
      shift_d = {`SLHV_WORD_W{1'b0}};
    end else if (shift_en) begin
      // shift toward MSB
      // A frame longer than the word keeps only its last bits
      shift_d = {shift_q[`SLHV_WORD_W-2:0], sdat_s};
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      shift_q <= {`SLHV_WORD_W{1'b0}};
    end else begin
      shift_q <= shift_d;
    end
  end

  // ====================================================================
  // Holding latches
  assign pattern_pick = shift_q[`SLHV_SEL_BIT];

  always @* begin
    cfg_d = cfg_q;
    pattern_d = pattern_q;
    if (strobe_rise) begin
      if (pattern_pick) begin
        pattern_d = shift_q[`SLHV_PAT_HI:`SLHV_PAT_LO] & out_mask;
      end else begin
        // Unimplemented upper bits fall away in the slice
        cfg_d = shift_q[`SLHV_CFG_W-1:0] & `SLHV_CFG_MASK;
      end
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      cfg_q <= {`SLHV_CFG_W{1'b0}};
      pattern_q <= {`SLHV_OUT_N{1'b0}};
    end else begin
      cfg_q <= cfg_d;
      pattern_q <= pattern_d;
    end
  end

  // ====================================================================
  // Word decode
  // Boost variant has fewer outputs; upper pattern bits are discarded
  assign out_mask = variant_mask(BOOST_VARIANT);

  assign level_code = cfg_q[`SLHV_CFG_LVL_HI:`SLHV_CFG_LVL_LO];
  assign limit_code = cfg_q[`SLHV_CFG_ILIM_HI:`SLHV_CFG_ILIM_LO];
  assign boost_on = (level_code != `SLHV_LVL_SHUTDOWN);

  // ====================================================================
  // Soft start
  // Line-driver variant has no regulator, so no soft start transient there
  assign ss_boost_on = boost_on & (BOOST_VARIANT != 0);

  slhv_softstart #(
    .SS_CYCLES(SS_CYCLES)
  ) u_ss (
    .clk(clk),
    .srst(srst),
    .boost_on(ss_boost_on),
    .softstart_off(cfg_q[`SLHV_CFG_SSOFF]),
    .pwm_rise(pwm_rise),
    .active(ss_active)
  );

  // ====================================================================
  // Next output values
  always @* begin
    // high impedance in shutdown or soft start
    if (!boost_on || ss_active) begin
      hv_output_d = {`SLHV_OUT_N{1'b0}};
      hv_output_oe_d = {`SLHV_OUT_N{1'b0}};
    end else if (gate_s) begin
      hv_output_d = pattern_q;
      hv_output_oe_d = out_mask;
    end else begin
      hv_output_d = {`SLHV_OUT_N{1'b0}};
      hv_output_oe_d = out_mask;
    end
    boost_level_sel_d = level_code;
    // limit forced low during soft start
    current_limit_sel_d = ss_active ? `SLHV_ILIM_200MA : limit_code;
    limiter_off_d = cfg_q[`SLHV_CFG_LIMOFF];
    regulator_sync_release_d = cfg_q[`SLHV_CFG_SYNC];
    softstart_off_d = cfg_q[`SLHV_CFG_SSOFF];
    softstart_active_d = ss_active;
    shutdown_d = ~boost_on;
  end

  // ====================================================================
  // Registered outputs
  always @(posedge clk) begin
    if (srst) begin
      hv_output <= {`SLHV_OUT_N{1'b0}};
      hv_output_oe <= {`SLHV_OUT_N{1'b0}};
      boost_level_sel <= `SLHV_LVL_SHUTDOWN;
      current_limit_sel <= `SLHV_ILIM_200MA;
      limiter_off <= 1'b0;
      regulator_sync_release <= 1'b0;
      softstart_off <= 1'b0;
      softstart_active <= 1'b0;
      shutdown <= 1'b1;
    end else begin
      hv_output <= hv_output_d;
      hv_output_oe <= hv_output_oe_d;
      boost_level_sel <= boost_level_sel_d;
      current_limit_sel <= current_limit_sel_d;
      limiter_off <= limiter_off_d;
      regulator_sync_release <= regulator_sync_release_d;
      softstart_off <= softstart_off_d;
      softstart_active <= softstart_active_d;
      shutdown <= shutdown_d;
    end
  end
endmodule

// ---- tb/slhv_chk_sva.sv ----
`timescale 1ns/1ps
module slhv_chk #(
  parameter BOOST_VARIANT = 1
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Watched pins
  input wire output_gate,
  input wire load_strobe_n,
  input wire [20:0] hv_output,
  input wire [20:0] hv_output_oe,
  input wire [2:0] boost_level_sel,
  input wire [1:0] current_limit_sel,
  input wire limiter_off,
  input wire softstart_active,
  input wire shutdown
);
  // ==========================================
  // Output stage
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Gate pin passes a synchroniser, so allow it to settle
  sequence gate_low_settled;
    !output_gate [*5];
  endsequence
  a_gate_low_ground: assert property (gate_low_settled |-> (hv_output & hv_output_oe) == 0)
    else $error("output driven high while gate low");
  a_shut_hiz: assert property (shutdown && $past(shutdown) |-> hv_output_oe == 0)
    else $error("output driven in shutdown");
  a_ss_hiz: assert property (softstart_active && $past(softstart_active) |-> hv_output_oe == 0)
    else $error("output driven in soft start");
  a_unimpl_off: assert property (BOOST_VARIANT != 0 |-> hv_output_oe[20:19] == 2'h0)
    else $error("missing output driven");
  // ==========================================
  // Configuration
  a_reset_clear: assert property ($fell(srst) |-> shutdown && hv_output_oe == 0)
    else $error("state not cleared by reset");
  a_shut_code: assert property ($stable(boost_level_sel) [*2] |-> shutdown == (boost_level_sel == 3'h0))
    else $error("shutdown does not follow level code");
  a_ss_limit: assert property (softstart_active && $past(softstart_active) |-> current_limit_sel == 2'h0)
    else $error("limit not low in soft start");
  a_strobe_hold: assert property (load_strobe_n [*8] |=> $stable({limiter_off, boost_level_sel}))
    else $error("config changed without strobe");
endmodule
bind slhv_top slhv_chk #(.BOOST_VARIANT(BOOST_VARIANT)) u_slhv_chk (.clk(clk), .srst(srst),
  .output_gate(output_gate), .load_strobe_n(load_strobe_n), .hv_output(hv_output),
  .hv_output_oe(hv_output_oe), .boost_level_sel(boost_level_sel),
  .current_limit_sel(current_limit_sel), .limiter_off(limiter_off),
  .softstart_active(softstart_active), .shutdown(shutdown));

// ---- tb/slhv_host.sv ----
`timescale 1ns/1ps
module slhv_host (
  // Clock
  input wire clk,
  // Serial link pins
  output logic serial_clk,
  output logic serial_data,
  output logic load_strobe_n
);
  initial begin
    serial_clk = 1'b0;
    serial_data = 1'b1;
    load_strobe_n = 1'b1;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic send(input logic [23:0] w, input int n, input logic hold_n);
    load_strobe_n = hold_n;
    gap(13);
    for (int i = n - 1; i >= 0; i--) begin
      serial_clk = 1'b1;
      gap(6);
      serial_data = w[i];
      gap(6);
      serial_clk = 1'b0;
      gap(13);
    end
    // Released line shows the inverse, never a stale bit
    serial_data = ~serial_data;
    load_strobe_n = 1'b1;
    gap(13);
  endtask
endmodule

// ---- tb/slhv_tb_top.sv ----
`timescale 1ns/1ps
module slhv_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic output_gate = 1'b1;
  logic boost_pwm_in = 1'b0;
  wire serial_clk, serial_data, load_strobe_n;
  wire [20:0] hv_output, hv_output_oe;
  wire [2:0] boost_level_sel;
  wire [1:0] current_limit_sel;
  wire limiter_off, regulator_sync_release, softstart_off, softstart_active, shutdown;
  int n_errors = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  // Short soft start keeps the run brief
  slhv_top #(.BOOST_VARIANT(1), .SS_CYCLES(8)) u_slhv_top (.clk(clk), .srst(srst),
    .serial_clk(serial_clk), .serial_data(serial_data), .load_strobe_n(load_strobe_n),
    .output_gate(output_gate), .boost_pwm_in(boost_pwm_in), .hv_output(hv_output),
    .hv_output_oe(hv_output_oe), .boost_level_sel(boost_level_sel),
    .current_limit_sel(current_limit_sel), .limiter_off(limiter_off),
    .regulator_sync_release(regulator_sync_release), .softstart_off(softstart_off),
    .softstart_active(softstart_active), .shutdown(shutdown));
  slhv_host u_slhv_host (.clk(clk), .serial_clk(serial_clk), .serial_data(serial_data),
    .load_strobe_n(load_strobe_n));
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse;
    boost_pwm_in = 1'b1;
    repeat (10) @(negedge clk);
    boost_pwm_in = 1'b0;
    repeat (10) @(negedge clk);
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_softstart;
    u_slhv_host.send(24'h000032, 24, 1'b0);
    chk({softstart_active, current_limit_sel, boost_level_sel, hv_output_oe}, 27'h420_0000);
    repeat (7) pulse();
    chk(softstart_active, 1'b1);
    pulse();
    chk({softstart_active, current_limit_sel, shutdown}, 4'h6);
  endtask
  task automatic t_pattern;
    u_slhv_host.send(24'h0001e8, 24, 1'b0);
    chk({limiter_off, regulator_sync_release, softstart_off, current_limit_sel,
      boost_level_sel}, 8'hf4);
    u_slhv_host.send(24'heaaaab, 24, 1'b0);
    chk(hv_output, 21'h055555);
    chk(hv_output_oe, 21'h07ffff);
    chk(boost_level_sel, 3'h4);
    output_gate = 1'b0;
    repeat (8) @(negedge clk);
    chk({hv_output_oe, hv_output[2:0]}, 24'h3ffff8);
    output_gate = 1'b1;
    u_slhv_host.send(24'h000005, 3, 1'b0);
    repeat (8) @(negedge clk);
    chk(hv_output, 21'h000002);
    u_slhv_host.send(24'hffffff, 24, 1'b1);
    chk(hv_output, 21'h000002);
    u_slhv_host.send(24'h000000, 24, 1'b0);
    chk({shutdown, hv_output_oe}, 22'h200000);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    repeat (2) @(negedge clk);
    chk({shutdown, hv_output_oe, boost_level_sel}, 25'h1000000);
    t_softstart();
    t_pattern();
    close_out();
  end
  initial begin
    #300000;
    n_errors++;
    close_out();
  end
endmodule
